// File: rtl/pss_sequencer.sv
/*
 Control and state sequencing of a small terminal processor: strobes,
 reset generation, extension chain, boot counter, indirect, wait, refresh
 and power-up flip-flops. Timing phases arrive as one-cycle enables from
 a timing unit in the mclk domain; I/O bus inputs are synchronous.
*/
// Functional notes
// (RULE1) Low nibble strobe on phase 17 with ALU select
// (RULE2) High nibble strobe also needs no second-nibble wait
// (RULE3) Boot load eight, shift four, insert four
// (RULE4) Helper latch set by test/reset/jump, cleared fetch
// (RULE5) Active-low acknowledge gives read-ack and not-ack
// (RULE6) Boot entry or power reset asserts register reset
// (RULE7) Address strobe on refresh state b with I/O pulse
// (RULE8) Address clear on register reset at phase 17
// (RULE9) Address strobe on every phase 19
// (RULE10) Extension chain on phase 20, cleared by reset
// (RULE11) Extension states: save acc, save pc, loads
// (RULE12) Boot counter three flops on phase 20
// (RULE13) Boot codes 000 through 101 as listed
// (RULE14) Eight-bit state entered only after acknowledge
// (RULE15) Shift low nibble high, then load low nibble
// (RULE16) Final state loads data register, returns waiting
// (RULE17) Boot line high inhibits; low restarts at zero
// (RULE18) Indirect set by bit 10, held by bit 15
// (RULE19) Wait flop on phase 17 from wait enable
// (RULE20) Refresh flops on refresh clock, reset cleared
// (RULE21) Power-up drives state reset each free-run pulse
// (RULE22) Boot entry clears non-boot flops, counter runs
// (RULE23) First phase 20 ends the power-up cycle
// (RULE24) Timing unit issues ordered one-cycle phase pulses
`timescale 1ns/100ps
`include "pss_params.svh"
module pss_sequencer
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Timing unit phase enables, one cycle each
    input wire logic phase_seventeen,
    input wire logic phase_nineteen,
    input wire logic phase_twenty,
    input wire logic io_timing_pulse,
    input wire logic refresh_clock,
    input wire logic free_run_pulse,
    // Decodes from the instruction logic
    input wire logic alu_to_acc_select,
    input wire logic successful_test,
    input wire logic jump_indirect,
    input wire logic fetch_phase_a,
    input wire logic ext_start,
    input wire logic wait_enable,
    input wire logic refresh_request,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] fetched_addr,
    input wire logic fetch_addr_valid,
    input wire logic boot_start,
    // I/O bus side
    input wire logic io_ack_n,
    input wire logic io_rio_pending,
    input wire logic io_bus_reset_request_n,
    input wire logic io_boot,
    input wire logic [7:0] io_data,
    // Strobes and resets
    output logic acc_low_nibble_strobe,
    output logic acc_high_nibble_strobe,
    output logic addr_reg_strobe,
    output logic addr_reg_clear,
    output logic register_reset_n,
    output logic io_reset_n,
    output logic read_io_acknowledged_n,
    output logic io_not_acknowledged_n,
    // State outputs
    output logic save_acc_status_state,
    output logic save_pc_state,
    output logic load_acc_status_state,
    output logic load_pc_state,
    output logic [2:0] boot_count,
    output logic boot_second_nibble_wait,
    output logic boot_inhibit,
    output logic pc_restart,
    output logic indirect_state_flop,
    output logic wait_flop,
    output logic refresh_state_a,
    output logic refresh_state_b,
    output logic power_up,
    output logic power_reset_n,
    output logic indirect_helper_latch,
    output logic state_counter_reset_n,
    output logic [7:0] accumulator,
    output logic mdr_load,
    output logic [7:0] memory_data
);
    pss_pkg::pss_state_t s_q, s_d;
    logic boot_entry;
    logic power_reset;

    // Boot entry decode and power reset level; power reset is the
    // first phase 20 that ends power-up
    assign boot_entry = (s_q.boot_cnt == `PSS_BOOT_ENTRY);
    assign power_reset = s_q.power_up & phase_twenty;

    // Next-state logic for the whole sequencer
    always_comb
    begin
        s_d = s_q;
        // Strobes are single-cycle pulses
        s_d.acc_lo_strb = phase_seventeen & alu_to_acc_select; // [RULE1]
        s_d.acc_hi_strb = phase_seventeen & alu_to_acc_select
            & (s_q.boot_cnt != `PSS_BOOT_LOAD4); // [RULE2]
        s_d.mar_strb = (s_q.ref_st == pss_pkg::REF_B && io_timing_pulse)
            || phase_nineteen; // [RULE7] [RULE9]
        s_d.mar_clr = !s_q.reg_rst_n && phase_seventeen; // [RULE8]
        // Register and bus resets from boot entry or power reset
        s_d.reg_rst_n = !(boot_entry || power_reset); // [RULE6]
        s_d.io_rst_n = s_d.reg_rst_n && io_bus_reset_request_n; // [RULE6]
        // Acknowledge sensing, both indications active low
        s_d.rio_ack_n = !(!io_ack_n && io_rio_pending); // [RULE5]
        s_d.io_nack_n = !(io_ack_n && io_rio_pending); // [RULE5]
        // Helper latch: set dominates the fetch clear
        if (successful_test || power_reset || jump_indirect)
            s_d.helper = 1'b1; // [RULE4]
        else if (fetch_phase_a)
            s_d.helper = 1'b0; // [RULE4]
        // Power-up holds the state counter in reset on free-run pulses
        s_d.scr_rst_n = !(s_q.power_up && free_run_pulse); // [RULE21]
        if (phase_twenty)
            s_d.power_up = 1'b0; // [RULE23]
        // Extension chain, shifted along on phase 20
        if (phase_twenty)
            s_d.ext_chain = {s_q.ext_chain[2:0], ext_start}; // [RULE10] [RULE11]
        // Indirect flop
        if (phase_twenty)
        begin
            if (instr_word[`PSS_IND_INSTR_BIT])
                s_d.indirect = 1'b1; // [RULE18]
            else if (s_q.indirect && fetch_addr_valid)
                s_d.indirect = fetched_addr[`PSS_IND_ADDR_BIT]; // [RULE18]
        end
        // Wait flop sampled on phase 17
        if (phase_seventeen)
            s_d.wait_f = wait_enable; // [RULE19]
        // Refresh pair stepped by the refresh clock enable
        if (refresh_clock)
        begin
            case (s_q.ref_st)
                pss_pkg::REF_IDLE: s_d.ref_st = refresh_request ? pss_pkg::REF_A
                    : pss_pkg::REF_IDLE; // [RULE20]
                pss_pkg::REF_A: s_d.ref_st = pss_pkg::REF_B;
                pss_pkg::REF_B: s_d.ref_st = pss_pkg::REF_C;
                pss_pkg::REF_C: s_d.ref_st = pss_pkg::REF_IDLE;
                default: s_d.ref_st = pss_pkg::REF_IDLE;
            endcase
        end
        // Boot data path controls, pulses
        s_d.acc_load8 = 1'b0;
        s_d.acc_shift = 1'b0;
        s_d.acc_load4 = 1'b0;
        s_d.mdr_load = 1'b0;
        s_d.pc_restart = 1'b0;
        // Boot counter on phase 20
        if (phase_twenty)
        begin
            case (s_q.boot_cnt) // [RULE12] [RULE13]
                `PSS_BOOT_IDLE: if (boot_start) s_d.boot_cnt = `PSS_BOOT_ENTRY;
                `PSS_BOOT_ENTRY:
                    if (!io_ack_n)
                    begin
                        s_d.boot_cnt = `PSS_BOOT_LOAD8; // [RULE14]
                        s_d.acc_load8 = 1'b1;
                    end
                `PSS_BOOT_LOAD8:
                begin
                    s_d.boot_cnt = `PSS_BOOT_SHIFT;
                    s_d.acc_shift = 1'b1; // [RULE15]
                end
                `PSS_BOOT_SHIFT:
                begin
                    s_d.boot_cnt = `PSS_BOOT_LOAD4;
                    s_d.acc_load4 = 1'b1; // [RULE15]
                end
                `PSS_BOOT_LOAD4:
                begin
                    s_d.boot_cnt = `PSS_BOOT_LOADMDR;
                    s_d.mdr_load = 1'b1; // [RULE16]
                end
                `PSS_BOOT_LOADMDR: s_d.boot_cnt = `PSS_BOOT_ENTRY; // [RULE16]
                default: s_d.boot_cnt = `PSS_BOOT_IDLE;
            endcase
        end
        // Accumulator assembly of a boot character
        if (s_q.acc_load8)
            s_d.acc = io_data; // [RULE3] [RULE14]
        else if (s_q.acc_shift)
            s_d.acc = {s_q.acc[3:0], 4'h0}; // [RULE3] [RULE15]
        else if (s_q.acc_load4)
            s_d.acc = {s_q.acc[7:4], io_data[3:0]}; // [RULE3] [RULE15]
        if (s_q.mdr_load)
            s_d.mdr_data = s_q.acc; // [RULE16]
        // Boot line: high inhibits, falling low restarts at zero
        s_d.boot_inhibit = io_boot; // [RULE17]
        if (!io_boot && s_q.boot_inhibit)
        begin
            s_d.boot_cnt = `PSS_BOOT_IDLE; // [RULE17]
            s_d.pc_restart = 1'b1; // [RULE17]
        end
        // Boot entry outside power-up clears non-boot state flops
        if (boot_entry && !s_q.power_up)
        begin
            s_d.ext_chain = 4'h0; // [RULE22]
            s_d.indirect = 1'b0;
            s_d.wait_f = 1'b0;
            s_d.ref_st = pss_pkg::REF_IDLE;
        end
        // Low state counter reset clears the eight state flops
        if (!s_q.scr_rst_n)
        begin
            s_d.ext_chain = 4'h0; // [RULE10] [RULE21]
            s_d.indirect = 1'b0; // [RULE18]
            s_d.wait_f = 1'b0;
            s_d.ref_st = pss_pkg::REF_IDLE; // [RULE20]
        end
    end

    // State register; phases arrive as enables per the timing unit
    always_ff @(posedge mclk) // [RULE24]
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.power_up <= `PSS_PUP_RESET;
            s_q.reg_rst_n <= 1'b1;
            s_q.io_rst_n <= 1'b1;
            s_q.rio_ack_n <= 1'b1;
            s_q.io_nack_n <= 1'b1;
            s_q.scr_rst_n <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from the state register
    assign acc_low_nibble_strobe = s_q.acc_lo_strb;
    assign acc_high_nibble_strobe = s_q.acc_hi_strb;
    assign addr_reg_strobe = s_q.mar_strb;
    assign addr_reg_clear = s_q.mar_clr;
    assign register_reset_n = s_q.reg_rst_n;
    assign io_reset_n = s_q.io_rst_n;
    assign read_io_acknowledged_n = s_q.rio_ack_n;
    assign io_not_acknowledged_n = s_q.io_nack_n;
    assign save_acc_status_state = s_q.ext_chain[0];
    assign save_pc_state = s_q.ext_chain[1];
    assign load_acc_status_state = s_q.ext_chain[2];
    assign load_pc_state = s_q.ext_chain[3];
    assign boot_count = s_q.boot_cnt;
    assign boot_second_nibble_wait = (s_q.boot_cnt == `PSS_BOOT_LOAD4);
    assign boot_inhibit = s_q.boot_inhibit;
    assign pc_restart = s_q.pc_restart;
    assign indirect_state_flop = s_q.indirect;
    assign wait_flop = s_q.wait_f;
    assign refresh_state_a = (s_q.ref_st == pss_pkg::REF_A);
    assign refresh_state_b = (s_q.ref_st == pss_pkg::REF_B);
    assign power_up = s_q.power_up;
    assign power_reset_n = !s_q.power_up;
    assign indirect_helper_latch = s_q.helper;
    assign state_counter_reset_n = s_q.scr_rst_n;
    assign accumulator = s_q.acc;
    assign mdr_load = s_q.mdr_load;
    assign memory_data = s_q.mdr_data;
endmodule // pss_sequencer

// File: rtl/pss_params.svh
/*
 Constants for the processor state sequencer: boot counter codes,
 power-up reset value, instruction and address bits tested by the indirect loop.
 Assumes inclusion from the package, the sequencer module and the checker.
*/
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
`define PSS_BOOT_IDLE 3'h0
`define PSS_BOOT_ENTRY 3'h1
`define PSS_BOOT_LOAD8 3'h2
`define PSS_BOOT_SHIFT 3'h3
`define PSS_BOOT_LOAD4 3'h4
`define PSS_BOOT_LOADMDR 3'h5
`define PSS_IND_INSTR_BIT 10
`define PSS_IND_ADDR_BIT 15
`define PSS_PUP_RESET 1'h1
`endif

// File: rtl/pss_pkg.sv
/*
 Types of the processor state sequencer: refresh states and the packed
 state record. Assumes pss_params.svh is reachable on the include path.
*/
`include "pss_params.svh"
package pss_pkg;
    typedef enum logic [1:0] {REF_IDLE, REF_A, REF_B, REF_C} pss_ref_t;
    typedef struct packed {
        logic [3:0] ext_chain;
        logic [2:0] boot_cnt;
        logic indirect;
        logic wait_f;
        pss_ref_t ref_st;
        logic power_up;
        logic helper;
        logic acc_lo_strb;
        logic acc_hi_strb;
        logic mar_strb;
        logic mar_clr;
        logic reg_rst_n;
        logic io_rst_n;
        logic rio_ack_n;
        logic io_nack_n;
        logic boot_inhibit;
        logic pc_restart;
        logic scr_rst_n;
        logic [7:0] acc;
        logic mdr_load;
        logic [7:0] mdr_data;
        logic acc_shift;
        logic acc_load8;
        logic acc_load4;
    } pss_state_t;
endpackage

// File: bench/pss_io_model.sv
/*
 Peripheral model on the I/O bus: acknowledges boot entry and drives a byte.
 Assumes the bench supplies the byte and the slow flag in the mclk domain.
*/
`timescale 1ns/100ps
module pss_io_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control from bench and sequencer
    input wire logic slow,
    input wire logic [2:0] boot_count,
    input wire logic [7:0] byte_in,
    // Bus lines
    output logic m_ack_n,
    output logic [7:0] m_data
);
    // Released data line toggles so no stale byte reads as valid
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            m_ack_n <= 1'h1;
            m_data <= 8'h00;
        end
        else
        begin
            m_ack_n <= !(boot_count == 3'h1 && !slow);
            m_data <= (boot_count inside {[3'h1:3'h4]} && !slow) ? byte_in : ~m_data;
        end
    end
endmodule // pss_io_model

// File: bench/pss_sequencer_chk.sv
/*
 Checker on the sequencer ports: strobes, acknowledge and boot steps.
 Assumes binding to pss_sequencer by port names.
*/
`timescale 1ns/100ps
`include "pss_params.svh"
module pss_sequencer_chk
(
    // Watched ports
    input wire logic mclk,
    input wire logic rst,
    input wire logic phase_seventeen,
    input wire logic phase_nineteen,
    input wire logic phase_twenty,
    input wire logic alu_to_acc_select,
    input wire logic io_ack_n,
    input wire logic io_rio_pending,
    input wire logic io_boot,
    input wire logic acc_low_nibble_strobe,
    input wire logic acc_high_nibble_strobe,
    input wire logic addr_reg_strobe,
    input wire logic read_io_acknowledged_n,
    input wire logic save_acc_status_state,
    input wire logic save_pc_state,
    input wire logic state_counter_reset_n,
    input wire logic [2:0] boot_count,
    input wire logic boot_second_nibble_wait,
    input wire logic power_up
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Boot steps taken on a phase twenty with the boot line still high
    sequence s_entry_go;
        boot_count == `PSS_BOOT_ENTRY && phase_twenty && io_boot;
    endsequence
    sequence s_shift_go;
        boot_count == `PSS_BOOT_SHIFT && phase_twenty && io_boot;
    endsequence
    a_low_nib_strobe: assert property (phase_seventeen && alu_to_acc_select |=> acc_low_nibble_strobe) else $error("low strobe missing");
    a_high_nib_gate: assert property (acc_high_nibble_strobe |-> $past(phase_seventeen && alu_to_acc_select && !boot_second_nibble_wait)) else $error("high strobe bad");
    a_addr_t19_strobe: assert property (phase_nineteen |=> addr_reg_strobe) else $error("addr strobe missing");
    a_ack_read_sense: assert property (!io_ack_n && io_rio_pending |=> !read_io_acknowledged_n) else $error("read ack missing");
    a_entry_ack_step: assert property (s_entry_go |=> boot_count == ($past(io_ack_n) ? `PSS_BOOT_ENTRY : `PSS_BOOT_LOAD8)) else $error("entry step bad");
    a_shift_to_load: assert property (s_shift_go |=> boot_count == `PSS_BOOT_LOAD4) else $error("shift step bad");
    a_ext_chain_step: assert property (save_acc_status_state && phase_twenty && state_counter_reset_n && boot_count != `PSS_BOOT_ENTRY |=> save_pc_state) else $error("chain step bad");
    a_power_up_end: assert property (power_up && phase_twenty |=> !power_up) else $error("power up stuck");
endmodule // pss_sequencer_chk

// File: bench/pss_sequencer_bench.sv
/*
 Bench of the sequencer: power-up, random strobes, boot character walk.
 Assumes pss_sequencer, its checker and the peripheral model compiled first.
*/
`timescale 1ns/100ps
module pss_sequencer_bench;
    logic mclk = 0, rst = 1, phase_seventeen = 0, phase_nineteen = 0, phase_twenty = 0;
    logic io_timing_pulse = 0, refresh_clock = 0, free_run_pulse = 0, alu_to_acc_select = 0;
    logic successful_test = 0, jump_indirect = 0, fetch_phase_a = 0, ext_start = 0;
    logic wait_enable = 0, refresh_request = 0, fetch_addr_valid = 0, boot_start = 0;
    logic io_rio_pending = 0, io_bus_reset_request_n = 1, io_boot = 1, r_ack_n = 1;
    logic boot_mode = 0, slow = 0, m_ack_n, io_ack_n;
    logic [15:0] instr_word = 0, fetched_addr = 0;
    logic [7:0] io_data, m_data, r_data = 0, byte_in = 0, d1, d2;
    logic acc_low_nibble_strobe, acc_high_nibble_strobe, addr_reg_strobe, addr_reg_clear;
    logic register_reset_n, io_reset_n, read_io_acknowledged_n, io_not_acknowledged_n;
    logic save_acc_status_state, save_pc_state, load_acc_status_state, load_pc_state;
    logic boot_second_nibble_wait, boot_inhibit, pc_restart, indirect_state_flop, wait_flop;
    logic refresh_state_a, refresh_state_b, power_up, power_reset_n, indirect_helper_latch;
    logic state_counter_reset_n, mdr_load, ea, em, ek, ew, ehl;
    logic [2:0] boot_count;
    logic [7:0] accumulator, memory_data;
    logic [31:0] x = 32'h0000E866, r;
    int n_fail = 0, compares = 0, cyc = 0;
    // Bus mux: model owns the acknowledge only in boot tests
    assign io_ack_n = boot_mode ? m_ack_n : r_ack_n;
    assign io_data = boot_mode ? m_data : r_data;
    pss_sequencer DUT (.*);
    pss_io_model u_io (.mclk(mclk), .rst(rst), .slow(slow), .boot_count(boot_count),
        .byte_in(byte_in), .m_ack_n(m_ack_n), .m_data(m_data));
    always #5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One phase twenty pulse, outputs settled after
    task automatic ph20();
        phase_twenty <= 1;
        @(posedge mclk);
        phase_twenty <= 0;
        @(posedge mclk);
        #1;
    endtask
    // Hang guard, well above the run length
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            finish_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        #1 chk(power_up, 1);
        @(posedge mclk);
        ext_start <= 1;
        ph20();
        chk(power_up, 0);
        chk(save_acc_status_state, 1);
        ext_start <= 0;
        ph20();
        chk(save_pc_state, 1);
        $display("power and chain test done");
        ea = 0;
        em = 0;
        ek = 0;
        ew = 0;
        ehl = 1;
        repeat (400)
        begin
            @(posedge mclk);
            x = xs(x);
            r = x;
            {io_timing_pulse, phase_nineteen, phase_seventeen, alu_to_acc_select} <= r[3:0];
            {r_ack_n, io_rio_pending, fetch_phase_a, successful_test, wait_enable} <= r[8:4];
            {refresh_request, refresh_clock, free_run_pulse, jump_indirect} <= r[12:9];
            fetch_addr_valid <= r[13];
            instr_word <= r[31:16];
            fetched_addr <= r[15:0];
            r_data <= r[23:16];
            #1 chk(acc_low_nibble_strobe, ea);
            chk(addr_reg_strobe, em);
            chk(read_io_acknowledged_n, !ek);
            chk(acc_high_nibble_strobe, ea);
            chk(addr_reg_clear, 0);
            chk(wait_flop, ew);
            chk(indirect_helper_latch, ehl);
            // Bit map: r[1] phase 17, r[0] select, r[8] ack, r[7] pending
            ea = r[1] & r[0];
            em = r[2] | (refresh_state_b & r[3]);
            ek = !r[8] & r[7];
            ew = r[1] ? r[4] : ew;
            ehl = (r[5] | r[9]) ? 1'b1 : (r[6] ? 1'b0 : ehl);
        end
        {phase_seventeen, phase_nineteen, io_timing_pulse, refresh_request} <= 4'h0;
        $display("random strobe test done");
        boot_mode <= 1;
        slow <= 1;
        d1 = x[7:0];
        d2 = x[15:8];
        byte_in <= d1;
        boot_start <= 1;
        ph20();
        boot_start <= 0;
        chk(boot_count, 3'h1);
        chk(register_reset_n, 0);
        chk(io_reset_n, 0);
        repeat (3) @(posedge mclk);
        ph20();
        chk(boot_count, 3'h1);
        slow <= 0;
        repeat (3) @(posedge mclk);
        ph20();
        chk(boot_count, 3'h2);
        byte_in <= d2;
        ph20();
        chk(accumulator, {d1[3:0], 4'h0});
        ph20();
        chk(boot_second_nibble_wait, 1);
        ph20();
        chk(boot_count, 3'h5);
        chk(accumulator, {d1[3:0], d2[3:0]});
        chk(memory_data, {d1[3:0], d2[3:0]});
        chk(boot_inhibit, 1);
        io_boot <= 0;
        @(posedge mclk);
        #1 chk(pc_restart, 1);
        @(posedge mclk);
        #1 chk(boot_count, 3'h0);
        $display("boot walk test done");
        finish_test();
    end
endmodule // pss_sequencer_bench
bind pss_sequencer pss_sequencer_chk u_chk (.*);
